/* File: wwdt_defines.vh */
// Summary of operation
// RL1: Watchdog comes up enabled after every reset.
// RL2: Disable and enable instructions accepted anytime.
// RL3: Overflow before service raises a reset request.
// RL4: Service below window boundary raises reset request.
// RL5: Counter is sixteen bits, counting upward.
// RL6: Clock source and prescaler ratio are selectable.
// RL7: Counter loads from programmable reload value.
// RL8: Each valid service reloads the counter.
// RL9: Defaults give about 0.13 s at wakeup clock.
// RL10: Overflow on wrap; request held one cycle.
`ifndef WWDT_DEFINES_VH
`define WWDT_DEFINES_VH

// Bus geometry
`define WWDT_ADDR_W        8
`define WWDT_DATA_W        32

// Register byte offsets
`define WWDT_OFS_CTRL      8'h00
`define WWDT_OFS_CMD       8'h04
`define WWDT_OFS_RELOAD    8'h08
`define WWDT_OFS_WINDOW    8'h0C
`define WWDT_OFS_COUNT     8'h10
`define WWDT_OFS_STATUS    8'h14
`define WWDT_OFS_MASK      8'h18

// Control fields
`define WWDT_CTRL_SRC_BIT  0
`define WWDT_CTRL_DIV_BIT  1

// Command fields (write-only strobes)
`define WWDT_CMD_EN_BIT    0
`define WWDT_CMD_DIS_BIT   1
`define WWDT_CMD_SRV_BIT   2

// Status and mask fields
`define WWDT_ST_OVF_BIT    0
`define WWDT_ST_WIN_BIT    1
`define WWDT_ST_RUN_BIT    2
`define WWDT_EVT_W         2

// AXI responses
`define WWDT_RESP_OKAY     2'h0
`define WWDT_RESP_SLVERR   2'h2

// Counter and prescaler
`define WWDT_CNT_W         16
`define WWDT_CNT_MAX       16'hFFFF
`define WWDT_PRE_W         14
`define WWDT_PRE_LONG_LAST 14'h3FFF
`define WWDT_PRE_SHORT_LAST 8'hFF

// Timing of the power-up interval
`define WWDT_DEF_INTERVAL_MS 130
`define WWDT_WU_FREQ_KHZ     500

// Reset values: wakeup clock, divide by 16384, four ticks of 32.768 ms
`define WWDT_RST_CTRL      2'h1
`define WWDT_RST_RELOAD    16'hFFFC
`define WWDT_RST_WINDOW    16'h0000
`define WWDT_RST_MASK      2'h0

`endif

/* File: wwdt_prescaler.v */
`timescale 1ns/100ps
`default_nettype none
`include "wwdt_defines.vh"

module wwdt_prescaler (
  // Clock and reset
  input  wire clk,
  input  wire rst_n,
  // Control
  input  wire step,
  input  wire clear,
  input  wire div_short,
  // Output
  output reg  tick
);

  reg  [`WWDT_PRE_W-1:0] cnt_reg;
  wire                   last;

  // Short ratio only looks at the low byte, so 256 and 16384 share one counter
  assign last = div_short ? (cnt_reg[7:0] == `WWDT_PRE_SHORT_LAST) :
                            (cnt_reg == `WWDT_PRE_LONG_LAST); // RL6

  always @(posedge clk) begin
    if (!rst_n || clear) begin
      cnt_reg <= {`WWDT_PRE_W{1'b0}};
      tick    <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (step) begin
        if (last) begin
          cnt_reg <= {`WWDT_PRE_W{1'b0}};
          tick    <= 1'b1; // RL6
        end else begin
          cnt_reg <= cnt_reg + 14'h0001;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: wwdt_top.v */
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "wwdt_defines.vh"

module wwdt_top (
  // Clock and reset
  input  wire                      CLK,
  input  wire                      RST_N,
  // AXI4-Lite write address
  input  wire [`WWDT_ADDR_W-1:0]   S_AXI_AWADDR,
  input  wire                      S_AXI_AWVALID,
  output wire                      S_AXI_AWREADY,
  // AXI4-Lite write data
  input  wire [`WWDT_DATA_W-1:0]   S_AXI_WDATA,
  input  wire [3:0]                S_AXI_WSTRB,
  input  wire                      S_AXI_WVALID,
  output wire                      S_AXI_WREADY,
  // AXI4-Lite write response
  output reg  [1:0]                S_AXI_BRESP,
  output reg                       S_AXI_BVALID,
  input  wire                      S_AXI_BREADY,
  // AXI4-Lite read address
  input  wire [`WWDT_ADDR_W-1:0]   S_AXI_ARADDR,
  input  wire                      S_AXI_ARVALID,
  output wire                      S_AXI_ARREADY,
  // AXI4-Lite read data
  output reg  [`WWDT_DATA_W-1:0]   S_AXI_RDATA,
  output reg  [1:0]                S_AXI_RRESP,
  output reg                       S_AXI_RVALID,
  input  wire                      S_AXI_RREADY,
  // Wakeup oscillator clock, asynchronous
  input  wire                      WAKEUP_CLK,
  // Instruction strobes from the core
  input  wire                      WATCHDOG_ENABLE_INSTR,
  input  wire                      WATCHDOG_DISABLE_INSTR,
  input  wire                      WATCHDOG_SERVICE_INSTR,
  // Outputs
  output reg                       WDT_RST_REQ,
  output wire                      IRQ
);

  // Write channel holding registers
  reg                     aw_hold_reg;
  reg  [`WWDT_ADDR_W-1:0] awaddr_reg;
  reg                     w_hold_reg;
  reg  [`WWDT_DATA_W-1:0] wdata_reg;
  reg  [3:0]              wstrb_reg;
  wire                    do_write;
  wire                    ar_take;

  // Software state
  reg  [1:0]              ctrl_reg;
  reg  [`WWDT_CNT_W-1:0]  reload_reg;
  reg  [`WWDT_CNT_W-1:0]  window_reg;
  reg  [`WWDT_EVT_W-1:0]  status_reg;
  reg  [`WWDT_EVT_W-1:0]  status_next;
  reg  [`WWDT_EVT_W-1:0]  mask_reg;

  // Watchdog core state
  reg                     run_reg;
  reg  [`WWDT_CNT_W-1:0]  cnt_reg;
  reg  [`WWDT_CNT_W-1:0]  cnt_next;
  reg                     ovf_evt;
  reg                     win_evt;
  reg                     reload_now;

  // Wakeup clock synchroniser
  reg                     wu_s1_reg;
  reg                     wu_s2_reg;
  reg                     wu_s3_reg;
  reg                     wu_lvl_reg;
  wire                    wu_rise;

  // Decoded commands
  wire                    sel_ctrl;
  wire                    sel_cmd;
  wire                    sel_reload;
  wire                    sel_window;
  wire                    sel_status;
  wire                    sel_mask;
  wire                    wr_mapped;
  wire                    cmd_en;
  wire                    cmd_dis;
  wire                    cmd_srv;
  wire                    en_req;
  wire                    dis_req;
  wire                    srv_req;
  wire                    pre_step;
  wire                    pre_tick;

  function [`WWDT_CNT_W-1:0] merge16;
    input [`WWDT_CNT_W-1:0] old;
    input [`WWDT_DATA_W-1:0] data;
    input [3:0] strb;
    begin
      merge16 = old;
      if (strb[0]) begin
        merge16[7:0] = data[7:0];
      end
      if (strb[1]) begin
        merge16[15:8] = data[15:8];
      end
    end
  endfunction

  // Write path: address and data may arrive in either order
  assign S_AXI_AWREADY = !aw_hold_reg && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_hold_reg && !S_AXI_BVALID;
  assign do_write      = aw_hold_reg && w_hold_reg && !S_AXI_BVALID;

  assign sel_ctrl   = (awaddr_reg == `WWDT_OFS_CTRL);
  assign sel_cmd    = (awaddr_reg == `WWDT_OFS_CMD);
  assign sel_reload = (awaddr_reg == `WWDT_OFS_RELOAD);
  assign sel_window = (awaddr_reg == `WWDT_OFS_WINDOW);
  assign sel_status = (awaddr_reg == `WWDT_OFS_STATUS);
  assign sel_mask   = (awaddr_reg == `WWDT_OFS_MASK);
  assign wr_mapped  = sel_ctrl || sel_cmd || sel_reload || sel_window ||
                      sel_status || sel_mask ||
                      (awaddr_reg == `WWDT_OFS_COUNT);

  always @(posedge CLK) begin
    if (!RST_N) begin
      aw_hold_reg  <= 1'b0;
      awaddr_reg   <= {`WWDT_ADDR_W{1'b0}};
      w_hold_reg   <= 1'b0;
      wdata_reg    <= {`WWDT_DATA_W{1'b0}};
      wstrb_reg    <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `WWDT_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= {S_AXI_AWADDR[`WWDT_ADDR_W-1:2], 2'b00};
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= S_AXI_WDATA;
        wstrb_reg  <= S_AXI_WSTRB;
      end
      if (do_write) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_mapped ? `WWDT_RESP_OKAY : `WWDT_RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Read path: one outstanding read, data registered
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign ar_take       = S_AXI_ARVALID && S_AXI_ARREADY;

  always @(posedge CLK) begin
    if (!RST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= {`WWDT_DATA_W{1'b0}};
      S_AXI_RRESP  <= `WWDT_RESP_OKAY;
    end else if (ar_take) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP  <= `WWDT_RESP_OKAY;
      case ({S_AXI_ARADDR[`WWDT_ADDR_W-1:2], 2'b00})
        `WWDT_OFS_CTRL:   S_AXI_RDATA <= {30'h0, ctrl_reg};
        `WWDT_OFS_CMD:    S_AXI_RDATA <= 32'h00000000;
        `WWDT_OFS_RELOAD: S_AXI_RDATA <= {16'h0000, reload_reg};
        `WWDT_OFS_WINDOW: S_AXI_RDATA <= {16'h0000, window_reg};
        `WWDT_OFS_COUNT:  S_AXI_RDATA <= {16'h0000, cnt_reg};
        `WWDT_OFS_STATUS: S_AXI_RDATA <= {29'h0, run_reg, status_reg};
        `WWDT_OFS_MASK:   S_AXI_RDATA <= {30'h0, mask_reg};
        default: begin
          S_AXI_RDATA <= 32'h00000000;
          S_AXI_RRESP <= `WWDT_RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // Command strobes: register writes and core instructions act alike
  assign cmd_en  = do_write && sel_cmd && wstrb_reg[0] &&
                   wdata_reg[`WWDT_CMD_EN_BIT];
  assign cmd_dis = do_write && sel_cmd && wstrb_reg[0] &&
                   wdata_reg[`WWDT_CMD_DIS_BIT];
  assign cmd_srv = do_write && sel_cmd && wstrb_reg[0] &&
                   wdata_reg[`WWDT_CMD_SRV_BIT];
  assign en_req  = cmd_en || WATCHDOG_ENABLE_INSTR;
  assign dis_req = cmd_dis || WATCHDOG_DISABLE_INSTR;
  assign srv_req = cmd_srv || WATCHDOG_SERVICE_INSTR;

  // Configuration registers
  always @(posedge CLK) begin
    if (!RST_N) begin
      ctrl_reg   <= `WWDT_RST_CTRL;   // RL9
      reload_reg <= `WWDT_RST_RELOAD; // RL9
      window_reg <= `WWDT_RST_WINDOW;
      mask_reg   <= `WWDT_RST_MASK;
    end else if (do_write) begin
      if (sel_ctrl && wstrb_reg[0]) begin
        ctrl_reg <= wdata_reg[1:0]; // RL6
      end
      if (sel_reload) begin
        reload_reg <= merge16(reload_reg, wdata_reg, wstrb_reg); // RL7
      end
      if (sel_window) begin
        window_reg <= merge16(window_reg, wdata_reg, wstrb_reg); // RL4
      end
      if (sel_mask && wstrb_reg[0]) begin
        mask_reg <= wdata_reg[`WWDT_EVT_W-1:0];
      end
    end
  end

  // Wakeup clock: only the second and later stages are examined
  always @(posedge CLK) begin
    if (!RST_N) begin
      wu_s1_reg  <= 1'b0;
      wu_s2_reg  <= 1'b0;
      wu_s3_reg  <= 1'b0;
      wu_lvl_reg <= 1'b0;
    end else begin
      wu_s1_reg <= WAKEUP_CLK;
      wu_s2_reg <= wu_s1_reg;
      wu_s3_reg <= wu_s2_reg;
      if (wu_s2_reg == wu_s3_reg) begin
        wu_lvl_reg <= wu_s3_reg;
      end
    end
  end

  // Wakeup clock must stay at or below a quarter of the system clock to be counted
  assign wu_rise  = (wu_s2_reg == wu_s3_reg) && wu_s3_reg && !wu_lvl_reg;
  assign pre_step = run_reg && (ctrl_reg[`WWDT_CTRL_SRC_BIT] ? wu_rise : 1'b1); // RL6

  wwdt_prescaler u_pre (
    .clk       (CLK),
    .rst_n     (RST_N),
    .step      (pre_step),
    .clear     (reload_now),
    .div_short (ctrl_reg[`WWDT_CTRL_DIV_BIT]),
    .tick      (pre_tick)
  );

  // Run state: disable wins when both strobes coincide
  always @(posedge CLK) begin
    if (!RST_N) begin
      run_reg <= 1'b1; // RL1
    end else if (dis_req) begin
      run_reg <= 1'b0; // RL2
    end else if (en_req) begin
      run_reg <= 1'b1; // RL2
    end
  end

  // Counter, service checking and overflow
  always @* begin
    cnt_next   = cnt_reg;
    ovf_evt    = 1'b0;
    win_evt    = 1'b0;
    reload_now = 1'b0;
    if (run_reg && srv_req) begin
      if (cnt_reg < window_reg) begin
        win_evt = 1'b1; // RL4
      end
      cnt_next   = reload_reg; // RL8
      reload_now = 1'b1;
    end else if (run_reg && pre_tick) begin
      if (cnt_reg == `WWDT_CNT_MAX) begin
        ovf_evt    = 1'b1; // RL10
        cnt_next   = reload_reg; // RL7
        reload_now = 1'b1;
      end else begin
        cnt_next = cnt_reg + 16'h0001; // RL5
      end
    end
  end

  always @(posedge CLK) begin
    if (!RST_N) begin
      cnt_reg     <= `WWDT_RST_RELOAD; // RL1
      WDT_RST_REQ <= 1'b0;
    end else begin
      cnt_reg     <= cnt_next;
      WDT_RST_REQ <= ovf_evt || win_evt; // RL3
    end
  end

  // Sticky status: a new event beats a simultaneous write-one-to-clear
  always @* begin
    status_next = status_reg;
    if (do_write && sel_status && wstrb_reg[0]) begin
      status_next = status_reg & ~wdata_reg[`WWDT_EVT_W-1:0];
    end
    status_next[`WWDT_ST_OVF_BIT] = status_next[`WWDT_ST_OVF_BIT] | ovf_evt;
    status_next[`WWDT_ST_WIN_BIT] = status_next[`WWDT_ST_WIN_BIT] | win_evt;
  end

  always @(posedge CLK) begin
    if (!RST_N) begin
      status_reg <= {`WWDT_EVT_W{1'b0}};
    end else begin
      status_reg <= status_next;
    end
  end

  assign IRQ = |(status_reg & mask_reg);

endmodule
`default_nettype wire

/* File: wwdt_props.sv */
`timescale 1ns/100ps
`default_nettype none
module wwdt_props (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Bus handshakes
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Instructions and outputs
  input wire logic WATCHDOG_ENABLE_INSTR,
  input wire logic WATCHDOG_DISABLE_INSTR,
  input wire logic WDT_RST_REQ,
  input wire logic IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  // No path back to running: no enable strobe and no register write
  sequence s_quiet;
    (!WATCHDOG_ENABLE_INSTR && !S_AXI_AWVALID) [*8];
  endsequence

  req_pulse_a: assert property (WDT_RST_REQ |=> !WDT_RST_REQ)
    else $error("reset request held too long");
  off_quiet_a: assert property (WATCHDOG_DISABLE_INSTR ##1 s_quiet |-> !WDT_RST_REQ)
    else $error("request while stopped");
  wr_resp_a: assert property (s_wr_taken |-> ##[1:2] S_AXI_BVALID)
    else $error("write response missing");
  b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped");
  r_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID)
    else $error("read data dropped");
  rd_resp_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read data late");
  ar_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address taken while busy");
  aw_block_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while busy");
  // Interrupt only rises on a new event or on a mask write
  irq_cause_a: assert property ($rose(IRQ) |-> WDT_RST_REQ || $rose(S_AXI_BVALID))
    else $error("interrupt raised without cause");
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "wwdt_defines.vh"
module tb_top;
  logic        CLK = 0, RST_N = 0, wk = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdv, hold, rdata;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [2:0]  ins = 0;
  logic [1:0]  bresp, rresp, rsp;
  logic        awready, wready, bvalid, arready, rvalid, req, irq;
  int          fail_count = 0, checks = 0, n, i;
  logic [7:0]  ra [7] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h04};
  logic [31:0] rv [7] = '{32'h1, 32'hFFFC, 32'h0, 32'hFFFC, 32'h4, 32'h0, 32'h0};

  always #5 CLK = ~CLK;
  // Wakeup clock unrelated in phase, eight system cycles long
  always #40 wk = ~wk;

  wwdt_top uut (.CLK(CLK), .RST_N(RST_N), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .WAKEUP_CLK(wk), .WATCHDOG_ENABLE_INSTR(ins[0]), .WATCHDOG_DISABLE_INSTR(ins[1]),
    .WATCHDOG_SERVICE_INSTR(ins[2]), .WDT_RST_REQ(req), .IRQ(irq));

  task report_and_stop;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task tmo;
    fail_count++;
    $display("[FAIL] %0t bus timeout", $time);
    report_and_stop;
  endtask
  // Response ready is raised only after valid is seen, so the slave must hold it
  task wr(input [7:0] a, input [31:0] d);
    logic ap, wp;
    int k;
    @(posedge CLK);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1;
    ap = 1; wp = 1;
    for (k = 0; k < 50; k++) begin
      @(posedge CLK);
      if (bvalid && bready) break;
      if (bvalid) bready <= 1;
      if (ap && awready) begin awvalid <= 0; ap = 0; end
      if (wp && wready) begin wvalid <= 0; wp = 0; end
    end
    if (k == 50) tmo;
    rsp = bresp; bready <= 0;
  endtask
  task rd(input [7:0] a);
    logic ap;
    int k;
    @(posedge CLK);
    araddr <= a; arvalid <= 1; ap = 1;
    for (k = 0; k < 50; k++) begin
      @(posedge CLK);
      if (rvalid && rready) break;
      if (rvalid) rready <= 1;
      if (ap && arready) begin arvalid <= 0; ap = 0; end
    end
    if (k == 50) tmo;
    rdv = rdata; rsp = rresp; rready <= 0;
  endtask
  task pulse(input [2:0] v);
    @(posedge CLK); ins <= v;
    @(posedge CLK); ins <= 0;
  endtask
  task wait_req(input int mx);
    for (n = 0; n < mx && req !== 1'b1; n++) @(posedge CLK);
  endtask

  initial begin
    repeat (20) @(posedge CLK);
    RST_N <= 1;
    for (i = 0; i < 7; i++) begin rd(ra[i]); chk(rdv, rv[i]); end
    rd(8'h08);
    chk((32'h10000 - rdv) * (`WWDT_PRE_LONG_LAST + 1) / `WWDT_WU_FREQ_KHZ / 10, `WWDT_DEF_INTERVAL_MS / 10);
    rd(8'h1C); chk(rdv, 0); chk(rsp, `WWDT_RESP_SLVERR);
    wr(8'h1C, 1); chk(rsp, `WWDT_RESP_SLVERR);
    // System clock over 256 keeps each count short
    wr(8'h00, 2); wr(8'h08, 32'hFFFE); pulse(3'h4);
    rd(8'h10); chk(rdv, 32'hFFFE);
    wait_req(800); chk(n >= 510 && n <= 516, 1);
    rd(8'h14); chk(rdv, 5); chk(irq, 0);
    wr(8'h18, 1); chk(irq, 1);
    wr(8'h14, 1); chk(irq, 0);
    wr(8'h0C, 32'hFFFF); pulse(3'h4);
    wait_req(5); chk(n, 1);
    rd(8'h14); chk(rdv, 6);
    wr(8'h14, 3); wr(8'h0C, 0);
    pulse(3'h2); rd(8'h10); hold = rdv;
    wait_req(700); chk(n, 700);
    pulse(3'h4); rd(8'h10); chk(rdv, hold);
    rd(8'h14); chk(rdv, 0);
    wr(8'h04, 1); rd(8'h14); chk(rdv, 4);
    wr(8'h04, 2); rd(8'h14); chk(rdv, 0);
    pulse(3'h1); rd(8'h14); chk(rdv, 4);
    // Reset in mid-run while stopped must bring the watchdog back up
    pulse(3'h2);
    RST_N <= 0;
    repeat (2) @(posedge CLK);
    RST_N <= 1;
    rd(8'h14); chk(rdv, 4);
    rd(8'h10); chk(rdv, 32'hFFFC);
    wr(8'h08, 32'hFFFF); wr(8'h00, 0); pulse(3'h4);
    wait_req(17000); chk(n >= 16380 && n <= 16390, 1);
    wr(8'h00, 3); wr(8'h08, 32'hFFFE); wr(8'h04, 4);
    wait_req(4500); chk(n >= 4080 && n <= 4120, 1);
    report_and_stop;
  end
endmodule

bind wwdt_top wwdt_props u_props (.CLK(CLK), .RST_N(RST_N),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .WATCHDOG_ENABLE_INSTR(WATCHDOG_ENABLE_INSTR), .WATCHDOG_DISABLE_INSTR(WATCHDOG_DISABLE_INSTR),
  .WDT_RST_REQ(WDT_RST_REQ), .IRQ(IRQ));
`default_nettype wire
